/* secure_eeprom_write_command.v */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`include "write_cmd_defines.vh"
module secure_eeprom_write_command (
    input  wire         pclk,                // APB clock
    input  wire         presetn,             // Async reset, active low
    input  wire         psel,                // APB select
    input  wire         penable,             // APB enable
    input  wire         pwrite,              // APB direction
    input  wire [7:0]   paddr,               // APB byte address
    input  wire [31:0]  pwdata,              // APB write data
    output wire         pready,              // APB ready
    output reg  [31:0]  prdata,              // APB read data
    output wire         pslverr,             // APB error
    input  wire         config_locked,       // Config zone lock state
    input  wire         data_locked,         // Data and one-time zone lock state
    input  wire [255:0] slot_policy,         // Sixteen 16-bit slot policies
    input  wire [15:0]  mac_check_origin,    // Per-slot mac check origin
    input  wire [7:0]   onetime_area_policy, // One-time area policy byte
    input  wire [255:0] scratch_key,         // Scratch key value
    input  wire         key_valid,           // Scratch key valid flag
    input  wire         digest_origin_flag,  // Scratch key made by digest command
    input  wire         key_origin_flag,     // Scratch key origin flag
    input  wire [3:0]   digest_source_slot,  // Slot used to make scratch key
    output reg          mac_req,             // Pulse: start MAC check
    output reg  [255:0] mac_plaintext,       // Plaintext for MAC check
    output reg  [255:0] mac_expected,        // MAC received from host
    input  wire         mac_done,            // MAC check finished
    input  wire         mac_ok,              // MAC matched
    output reg          nvm_we,              // Memory word write strobe
    output reg  [1:0]   nvm_zone,            // Memory zone
    output reg  [6:0]   nvm_addr,            // Memory word address
    output reg  [31:0]  nvm_wdata,           // Memory word data
    output reg          nvm_and_mode,        // Memory ANDs data into the word
    input  wire         nvm_ready            // Memory accepted the word
);
    localparam S_IDLE  = 3'h0;
    localparam S_CHECK = 3'h1;
    localparam S_MAC   = 3'h2;
    localparam S_WRITE = 3'h3;
    localparam S_DONE  = 3'h4;

    reg  [2:0]   state_q;
    reg  [7:0]   opcode_q;
    reg  [7:0]   p1_q;
    reg  [15:0]  p2_q;
    reg  [255:0] data_q;
    reg  [255:0] mac_q;
    reg          done_q;
    reg  [7:0]   resp_q;
    reg  [3:0]   wcnt_q;
    reg          enc_q;
    reg  [7:0]   resp_d;
    reg          enc_d;
    reg          need_mac_d;
    integer      i;
    integer      k;
    reg  [31:0]  rdata_d;

    function [31:0] key_word;
        input [255:0] k;
        input [2:0]   idx;
        begin
            key_word = k[idx*32 +: 32];
        end
    endfunction

    // True when addr is word idx of the eight-word bank starting at base
    function word_hit;
        input [7:0] addr;
        input [7:0] base;
        input [2:0] idx;
        begin
            word_hit = (addr == base + {3'h0, idx, 2'h0});
        end
    endfunction

    // Decoded command fields
    wire [1:0]  zone     = p1_q[`P1_ZONE_LO +: 2];
    wire        enc_bit  = p1_q[`P1_ENC];
    wire        long_wr  = p1_q[`P1_LONG];
    wire [2:0]  word_ix  = long_wr ? 3'h0 : p2_q[`P2_WORD_HI:0];
    wire [3:0]  blk      = p2_q[`P2_BLK_HI:`P2_BLK_LO];
    wire [15:0] sp       = slot_policy[blk*`SP_WIDTH +: `SP_WIDTH];
    wire        sp_hid   = sp[`SP_HIDDEN];
    wire        sp_always = (sp[`SP_WPOL_HI:`SP_WPOL_LO] == `WPOL_ALWAYS);
    wire [3:0]  sp_auth  = sp[`SP_AUTH_HI:`SP_AUTH_LO];
    wire        consume  = (onetime_area_policy == `OTP_POL_CONSUME);

    wire apb_acc = psel & penable;
    wire apb_wr  = apb_acc & pwrite;
    wire mapped  = (paddr[1:0] == 2'h0) && (paddr <= `REG_TOP) &&
                   !(paddr > `REG_STATUS && paddr < `REG_DATA_BASE);
    wire busy    = (state_q != S_IDLE);
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~mapped;

    // Command checking; first failure found sets the status
    always @* begin
        resp_d = `RESP_OK;
        enc_d = 1'b0;
        need_mac_d = 1'b0;
        if (opcode_q != `OPC_WRITE || p1_q[`P1_RSVD_HI:`P1_RSVD_LO] != 4'h0) begin
            resp_d = `RESP_PARSE_ERR;
        end else if (zone == `ZONE_CFG) begin
            if (blk > `CFG_LAST_BLK || (blk == `CFG_LAST_BLK &&
                (long_wr || word_ix > `CFG_LAST_WORD)))
                resp_d = `RESP_PARSE_ERR;
            else if (config_locked || enc_bit)
                resp_d = `RESP_EXEC_ERR;
            else if (blk == 4'h0 && (long_wr || word_ix < `CFG_PROT_WORDS))
                resp_d = `RESP_EXEC_ERR;
        end else if (zone == `ZONE_OTP || zone == `ZONE_DATA) begin
            enc_d = (data_locked && zone == `ZONE_DATA) ? sp[`SP_ENC] : enc_bit;
            need_mac_d = enc_d && (zone == `ZONE_DATA);
            if (zone == `ZONE_OTP && blk > `OTP_LAST_BLK)
                resp_d = `RESP_PARSE_ERR;
            else if (!config_locked)
                resp_d = `RESP_EXEC_ERR;
            else if (!data_locked && !long_wr)
                resp_d = `RESP_EXEC_ERR;
            else if (!long_wr && (sp_hid || !sp_always || enc_d))
                resp_d = `RESP_EXEC_ERR;
            else if (zone == `ZONE_OTP && data_locked && (enc_d || !consume))
                resp_d = `RESP_EXEC_ERR;
            else if (enc_d && !(key_valid && digest_origin_flag))
                resp_d = `RESP_EXEC_ERR;
            else if (enc_d && zone == `ZONE_DATA && data_locked &&
                     digest_source_slot != sp_auth)
                resp_d = `RESP_EXEC_ERR;
            else if (enc_d && zone == `ZONE_DATA && (blk[0] ?
                     (key_origin_flag != mac_check_origin[blk]) :
                     (key_origin_flag != `ORIGIN_RANDOM)))
                resp_d = `RESP_EXEC_ERR;
        end else begin
            resp_d = `RESP_PARSE_ERR;
        end
    end

    // Register file and command engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            opcode_q <= 8'h00;
            p1_q <= 8'h00;
            p2_q <= 16'h0000;
            data_q <= 256'h0;
            mac_q <= 256'h0;
            done_q <= 1'b0;
            resp_q <= 8'h00;
            wcnt_q <= 4'h0;
            enc_q <= 1'b0;
            mac_req <= 1'b0;
            mac_plaintext <= 256'h0;
            mac_expected <= 256'h0;
            nvm_we <= 1'b0;
            nvm_zone <= 2'h0;
            nvm_addr <= 7'h00;
            nvm_wdata <= 32'h0;
            nvm_and_mode <= 1'b0;
        end else begin
            mac_req <= 1'b0;
            // Command buffers frozen while busy so checks see stable values
            if (apb_wr && mapped && !busy) begin
                if (paddr == `REG_CMD) begin
                    opcode_q <= pwdata[7:0];
                    p1_q <= pwdata[15:8];
                    p2_q <= pwdata[31:16];
                end
                for (i = 0; i < 8; i = i + 1) begin
                    if (word_hit(paddr, `REG_DATA_BASE, i[2:0]))
                        data_q[i*32 +: 32] <= pwdata;
                    if (word_hit(paddr, `REG_MAC_BASE, i[2:0]))
                        mac_q[i*32 +: 32] <= pwdata;
                end
            end
            if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_CLR_DONE])
                done_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_START])
                        state_q <= S_CHECK;
                end
                S_CHECK: begin
                    enc_q <= enc_d;
                    wcnt_q <= 4'h0;
                    for (i = 0; i < 8; i = i + 1)
                        mac_plaintext[i*32 +: 32] <= enc_d ?
                            data_q[i*32 +: 32] ^ key_word(scratch_key, i[2:0]) :
                            data_q[i*32 +: 32];
                    mac_expected <= mac_q;
                    if (resp_d != `RESP_OK) begin
                        resp_q <= resp_d;
                        state_q <= S_DONE;
                    end else if (need_mac_d) begin
                        mac_req <= 1'b1;
                        state_q <= S_MAC;
                    end else begin
                        state_q <= S_WRITE;
                    end
                end
                S_MAC: begin
                    if (mac_done) begin
                        if (mac_ok) begin
                            state_q <= S_WRITE;
                        end else begin
                            resp_q <= `RESP_MAC_ERR;
                            state_q <= S_DONE;
                        end
                    end
                end
                S_WRITE: begin
                    if (!nvm_we || nvm_ready) begin
                        if (wcnt_q == (long_wr ? `WORDS_LONG : `WORDS_SHORT)) begin
                            nvm_we <= 1'b0;
                            resp_q <= `RESP_OK;
                            state_q <= S_DONE;
                        end else begin
                            nvm_we <= 1'b1;
                            nvm_zone <= zone;
                            nvm_addr <= {blk, word_ix + wcnt_q[2:0]};
                            nvm_wdata <= mac_plaintext[wcnt_q[2:0]*32 +: 32];
                            nvm_and_mode <= (zone == `ZONE_OTP) && data_locked;
                            wcnt_q <= wcnt_q + 4'h1;
                        end
                    end
                end
                S_DONE: begin
                    done_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Read mux; MAC words stay write-only so the tag cannot be read back
    always @* begin
        rdata_d = 32'h0;
        if (paddr == `REG_CMD)
            rdata_d = {p2_q, p1_q, opcode_q};
        else if (paddr == `REG_STATUS) begin
            rdata_d[`ST_BUSY] = busy;
            rdata_d[`ST_DONE] = done_q;
            rdata_d[`ST_RESP_LO +: 8] = resp_q;
        end
        for (k = 0; k < 8; k = k + 1) begin
            if (word_hit(paddr, `REG_DATA_BASE, k[2:0]))
                rdata_d = data_q[k*32 +: 32];
        end
    end

    // Captured in the setup cycle so read data stands through the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= rdata_d;
        end
    end
endmodule

/* write_cmd_defines.vh */
`ifndef WRITE_CMD_DEFINES_VH
`define WRITE_CMD_DEFINES_VH
// APB register byte offsets
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08
`define REG_DATA_BASE   8'h10
`define REG_MAC_BASE    8'h30
`define REG_TOP         8'h4c
// Command fields
`define OPC_WRITE       8'h12
`define P1_ZONE_LO      0
`define P1_RSVD_HI      5
`define P1_RSVD_LO      2
`define P1_ENC          6
`define P1_LONG         7
`define P2_WORD_HI      2
`define P2_BLK_HI       6
`define P2_BLK_LO       3
// Zone encoding
`define ZONE_CFG        2'h0
`define ZONE_OTP        2'h1
`define ZONE_DATA       2'h2
// Zone extents, last valid block and last valid config word, and count of protected config words
`define CFG_LAST_BLK    4'h2
`define CFG_LAST_WORD   3'h5
`define OTP_LAST_BLK    4'h1
`define CFG_PROT_WORDS  3'h4
// Per-slot policy fields
`define SP_HIDDEN       7
`define SP_AUTH_HI      11
`define SP_AUTH_LO      8
`define SP_ENC          14
`define SP_WPOL_HI      15
`define SP_WPOL_LO      12
`define WPOL_ALWAYS     4'h0
`define SP_WIDTH        16
// One-time area policy codes and random key origin value
`define OTP_POL_RO      8'haa
`define OTP_POL_CONSUME 8'h55
`define OTP_POL_LEGACY  8'h00
`define ORIGIN_RANDOM   1'b0
// Response codes
`define RESP_OK         8'h00
`define RESP_MAC_ERR    8'h01
`define RESP_PARSE_ERR  8'h03
`define RESP_EXEC_ERR   8'h0f
// Control and status bits, and word counts of long and short writes
`define CTRL_START      0
`define CTRL_CLR_DONE   1
`define ST_BUSY         0
`define ST_DONE         1
`define ST_RESP_LO      8
`define WORDS_LONG      4'h8
`define WORDS_SHORT     4'h1
`endif

/* secure_eeprom_write_command_checker.sv */
`include "write_cmd_defines.vh"
module secure_eeprom_write_command_checker (
    input logic         pclk,          // Clock
    input logic         presetn,       // Reset, active low
    input logic         config_locked, // Config lock
    input logic         data_locked,   // Data lock
    input logic         mac_req,       // MAC start
    input logic [255:0] mac_plaintext, // MAC text
    input logic [255:0] mac_expected,  // MAC value
    input logic         mac_done,      // MAC answer
    input logic         mac_ok,        // MAC match
    input logic         nvm_we,        // Write strobe
    input logic [1:0]   nvm_zone,      // Zone
    input logic [6:0]   nvm_addr,      // Word address
    input logic [31:0]  nvm_wdata,     // Word data
    input logic         nvm_and_mode,  // AND write
    input logic         nvm_ready      // Accept
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_mac_launch;
        mac_req ##1 (!mac_req && !nvm_we);
    endsequence
    sequence s_mac_held;
        $stable(mac_plaintext) && $stable(mac_expected);
    endsequence
    AST_CFG_LOCKED: assert property (nvm_we && nvm_zone == `ZONE_CFG |-> !config_locked)
        else $error("config write after lock");
    AST_PROT_WORDS: assert property (nvm_we && nvm_zone == `ZONE_CFG |->
        nvm_addr[6:3] != 4'h0 || nvm_addr[2:0] >= `CFG_PROT_WORDS) else $error("protected word");
    AST_OTP_RANGE: assert property (nvm_we && nvm_zone == `ZONE_OTP |->
        nvm_addr[6:3] <= `OTP_LAST_BLK) else $error("one-time block out of range");
    AST_EARLY_WRITE: assert property (nvm_we && nvm_zone != `ZONE_CFG |-> config_locked)
        else $error("data write before config lock");
    AST_AND_MODE: assert property (nvm_we && nvm_and_mode |->
        data_locked && nvm_zone == `ZONE_OTP) else $error("and mode outside locked area");
    AST_WORD_HOLD: assert property (nvm_we && !nvm_ready |=>
        nvm_we && $stable(nvm_addr) && $stable(nvm_wdata)) else $error("word dropped");
    AST_MAC_FIRST: assert property (mac_req |-> s_mac_launch)
        else $error("mac pulse or early write");
    AST_MAC_HELD: assert property (mac_req |=> s_mac_held)
        else $error("mac operands moved");
    AST_MAC_FAIL: assert property (mac_done && !mac_ok |=> !nvm_we [*4])
        else $error("write after mac failure");
endmodule
bind secure_eeprom_write_command secure_eeprom_write_command_checker i_chk (
    .pclk(pclk), .presetn(presetn), .config_locked(config_locked),
    .data_locked(data_locked), .mac_req(mac_req), .mac_plaintext(mac_plaintext),
    .mac_expected(mac_expected), .mac_done(mac_done), .mac_ok(mac_ok), .nvm_we(nvm_we),
    .nvm_zone(nvm_zone), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_and_mode(nvm_and_mode), .nvm_ready(nvm_ready));

/* write_partner.sv */
module write_partner (
    input  logic        pclk,       // Clock
    input  logic        presetn,    // Reset, active low
    input  logic        slow,       // Stretch answers
    input  logic        mac_good,   // MAC verdict to give
    input  logic        nvm_we,     // Write strobe
    input  logic [6:0]  nvm_addr,   // Word address
    input  logic [31:0] nvm_wdata,  // Word data
    output logic        nvm_ready,  // Accept
    input  logic        mac_req,    // MAC start
    output logic        mac_done,   // MAC answer
    output logic        mac_ok,     // MAC match
    output int          words,      // Words accepted
    output logic [6:0]  last_addr,  // Last address
    output logic [31:0] last_wdata  // Last data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    logic [2:0] mw;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cnt, mw, nvm_ready, mac_done, mac_ok} <= '0;
            words <= 0;
        end else begin
            cnt <= cnt + 2'h1;
            nvm_ready <= nvm_we && !nvm_ready && (!slow || cnt == 2'h0);
            if (nvm_we && nvm_ready) begin
                words <= words + 1;
                last_addr <= nvm_addr;
                last_wdata <= nvm_wdata;
            end
            mw <= mac_req ? (slow ? 3'h5 : 3'h1) : (mw != 3'h0 ? mw - 3'h1 : mw);
            mac_done <= (mw == 3'h1);
            // Verdict is meaningless outside done, so it toggles
            mac_ok <= (mw == 3'h1) ? mac_good : ~mac_ok;
        end
    end
endmodule

/* tb_secure_eeprom_write_command.sv */
module tb_secure_eeprom_write_command;
    timeunit 1ns;
    timeprecision 1ps;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic         cl = 0, dl = 0, kv = 0, mg = 1, slow = 0, dg = 0, ko = 0;
    logic [3:0]   ds = 4'h5;
    logic [15:0]  mco = 16'haaaa;
    logic [7:0]   paddr = 8'h00, om = 8'h55, kb = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd, nvm_wdata, last_wdata, dat [8];
    logic [15:0]  sp = 16'h0000, pols [4] = '{16'h0000, 16'h0080, 16'h1000, 16'h4000};
    logic         pready, pslverr, mac_req, mac_done, mac_ok, nvm_we, nvm_and_mode, nvm_ready;
    logic [255:0] mac_plaintext, mac_expected;
    logic [1:0]   nvm_zone;
    logic [6:0]   nvm_addr, last_addr;
    int           words, i, fails = 0, samples_checked = 0;
    always #5 pclk = ~pclk;
    secure_eeprom_write_command i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .config_locked(cl), .data_locked(dl),
        .slot_policy({16{sp}}), .mac_check_origin(mco), .onetime_area_policy(om),
        .scratch_key({32{kb}}), .key_valid(kv), .digest_origin_flag(dg), .key_origin_flag(ko),
        .digest_source_slot(ds), .mac_req(mac_req), .mac_plaintext(mac_plaintext),
        .mac_expected(mac_expected), .mac_done(mac_done), .mac_ok(mac_ok), .nvm_we(nvm_we),
        .nvm_zone(nvm_zone), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_and_mode(nvm_and_mode), .nvm_ready(nvm_ready));
    write_partner i_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mac_good(mg),
        .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_ready(nvm_ready),
        .mac_req(mac_req), .mac_done(mac_done), .mac_ok(mac_ok), .words(words),
        .last_addr(last_addr), .last_wdata(last_wdata));
    task check(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin fails++; conclude(); end
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic exp_enc(logic [7:0] p1);
        return (dl && p1[1:0] == 2'h2) ? sp[14] : p1[6];
    endfunction
    function automatic logic exp_ok(logic [7:0] op, logic [7:0] p1, logic [6:0] a);
        logic [3:0] b;
        logic e, z1;
        b = a[6:3];
        z1 = (p1[1:0] == 2'h1);
        e = exp_enc(p1);
        if (op != 8'h12 || p1[5:2] != 4'h0 || p1[1:0] == 2'h3) return 0;
        if (p1[1:0] == 2'h0)
            return !cl && !p1[6] && (b < 2 || b == 2 && !p1[7] && a[2:0] < 6) &&
                !(b == 0 && (p1[7] || a[2:0] < 4));
        if (!cl || z1 && b > 1 || !dl && !p1[7]) return 0;
        if (!p1[7] && (sp[7] || sp[15:12] != 4'h0 || e)) return 0;
        if (z1 && dl) return !e && om == 8'h55;
        if (!e) return 1;
        if (!(kv && dg)) return 0;
        if (z1) return 1;
        if (dl && ds != sp[11:8]) return 0;
        return ko == (b[0] ? mco[b] : 1'b0) && mg;
    endfunction
    task run(logic [7:0] op, logic [7:0] p1, logic [6:0] a);
        int j, w0;
        logic ok;
        slow <= 1'($urandom % 2);
        apb(1, 8'h04, {9'h0, a, p1, op});
        ok = exp_ok(op, p1, a);
        for (j = 0; j < 8; j++) begin
            dat[j] = $urandom;
            apb(1, 8'h10 + 8'(4 * j), dat[j]);
        end
        apb(1, 8'h30, $urandom);
        w0 = words;
        apb(1, 8'h00, 32'h1);
        for (j = 0; j < 60; j++) begin
            apb(0, 8'h08, 32'h0);
            if (rd[1] === 1'b1) break;
        end
        if (j == 60) begin fails++; conclude(); end
        check("slverr", {31'h0, se}, 32'h0);
        check("resp_ok", {31'h0, rd[15:8] == 8'h00}, {31'h0, ok});
        check("words", 32'(words - w0), ok ? (p1[7] ? 32'd8 : 32'd1) : 32'd0);
        if (ok) begin
            check("wdata", last_wdata, (p1[7] ? dat[7] : dat[0]) ^ (exp_enc(p1) ? {4{kb}} : 32'h0));
            check("addr", {25'h0, last_addr}, {25'h0, a[6:3], p1[7] ? 3'h7 : a[2:0]});
        end
        apb(1, 8'h00, 32'h2);
    endtask
    initial begin
        void'($urandom(97));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        kb <= 8'($urandom);
        apb(0, 8'hfc, 32'h0);
        check("unmapped", {31'h0, se}, 32'h1);
        run(8'h12, 8'h00, 7'h08);
        run(8'h12, 8'h40, 7'h08);
        run(8'h12, 8'h00, 7'h02);
        run(8'h12, 8'h80, 7'h18);
        run(8'h12, 8'h81, 7'h00);
        run(8'h13, 8'h00, 7'h08);
        run(8'h12, 8'h04, 7'h08);
        cl <= 1'b1;
        run(8'h12, 8'h00, 7'h08);
        run(8'h12, 8'h01, 7'h08);
        run(8'h12, 8'h81, 7'h08);
        {kv, dg} <= 2'b11;
        run(8'h12, 8'hc2, 7'h10);
        mg <= 1'b0;
        run(8'h12, 8'hc2, 7'h10);
        {mg, dg} <= 2'b10;
        run(8'h12, 8'hc2, 7'h10);
        {dg, ko} <= 2'b11;
        run(8'h12, 8'hc2, 7'h10);
        run(8'h12, 8'hc2, 7'h18);
        {ko, dl} <= 2'b01;
        run(8'h12, 8'h81, 7'h08);
        run(8'h12, 8'hc1, 7'h08);
        run(8'h12, 8'h81, 7'h10);
        om <= 8'haa;
        run(8'h12, 8'h81, 7'h08);
        om <= 8'h00;
        run(8'h12, 8'h81, 7'h08);
        {om, sp} <= {8'h55, 16'h4500};
        run(8'h12, 8'h82, 7'h10);
        ds <= 4'h3;
        run(8'h12, 8'h82, 7'h10);
        for (i = 0; i < 8; i++) begin
            sp <= pols[$urandom % 4];
            run(8'h12, 8'h02, 7'($urandom));
        end
        conclude();
    end
endmodule
